// [design/qmh_crc_index.sv]
// Purpose: Hash index from the CRC-32 of a 48-bit destination address
// Assumes: Bytes go out first byte first, each byte least significant bit first
// Notes:   Pure combinational; the caller registers the result

`timescale 1ns/1ps
`default_nettype none

module qmh_crc_index (
    input  wire logic [47:0] dest_addr,
    output logic      [5:0]  hash_index
);
    import qmh_pkg::*;

    // ------------------------------------------------------------------
    // Serial CRC unrolled over all 48 bits
    // ------------------------------------------------------------------
    function automatic logic [31:0] crc_of_addr(input logic [47:0] a);
        logic [31:0] c;
        logic        fb;
        c  = CRC_INIT;
        fb = 1'b0;
        for (int b = 0; b < 6; b++) begin
            for (int i = 0; i < 8; i++) begin
                fb = c[31] ^ a[47 - 8*b - 7 + i];
                c  = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h0000_0000);
            end
        end
        return c;
    endfunction

    logic [31:0] crc_full;

    // Top six CRC bits form the index
    always_comb begin
        crc_full   = crc_of_addr(dest_addr);
        hash_index = crc_full[31:26];
    end

endmodule

`default_nettype wire

// [design/qmh_pkg.sv]
// Purpose: Shared constants for the queue threshold, space request and multicast hash block
// Assumes: AHB-Lite word registers, byte address is four times the register index
// Notes:   Register indices keep the odd 16-bit spacing of the map

package qmh_pkg;

    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W    = 12;
    localparam int unsigned IDX_W     = 9;
    localparam logic [1:0]  HTRANS_NS = 2'h2;
    localparam logic [2:0]  HSIZE_WD  = 3'h2;
    localparam logic        HRESP_OK  = 1'b0;

    // ------------------------------------------------------------------
    // Register indices
    // ------------------------------------------------------------------
    localparam logic [IDX_W-1:0] IDX_INT_STATUS = 9'h192;
    localparam logic [IDX_W-1:0] IDX_RX_THRESH  = 9'h19c;
    localparam logic [IDX_W-1:0] IDX_TX_REQUEST = 9'h19e;
    localparam logic [IDX_W-1:0] IDX_HASH_0     = 9'h1a0;
    localparam logic [IDX_W-1:0] IDX_HASH_1     = 9'h1a2;
    localparam logic [IDX_W-1:0] IDX_HASH_2     = 9'h1a4;
    localparam logic [IDX_W-1:0] IDX_HASH_3     = 9'h1a6;
    localparam logic [IDX_W-1:0] IDX_RXQ_CTRL   = 9'h1c0;
    localparam logic [IDX_W-1:0] IDX_TXQ_CTRL   = 9'h1c2;
    localparam logic [IDX_W-1:0] IDX_RX_CTRL1   = 9'h1c4;
    localparam logic [IDX_W-1:0] IDX_INT_MASK   = 9'h1c6;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned RXQ_THR_EN_BIT  = 5;
    localparam int unsigned TXQ_MON_BIT     = 1;
    localparam int unsigned ISR_RX_BIT      = 13;
    localparam int unsigned ISR_TXSPACE_BIT = 6;
    localparam int unsigned RXC1_RXALL_BIT  = 4;
    localparam int unsigned RXC1_MCMAC_BIT  = 8;
    localparam int unsigned RXC1_HASH_BIT   = 11;
    localparam int unsigned MCAST_DA_BIT    = 40;

    // ------------------------------------------------------------------
    // Writable masks and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] RXQ_CTRL_MASK = 16'h0020;
    localparam logic [15:0] TXQ_CTRL_MASK = 16'h0002;
    localparam logic [15:0] RX_CTRL1_MASK = 16'h0910;
    localparam logic [15:0] INT_MASK_MASK = 16'h2040;
    localparam logic [15:0] REG16_RESET   = 16'h0000;
    localparam logic [7:0]  THRESH_RESET  = 8'h00;

    // ------------------------------------------------------------------
    // Destination address CRC
    // ------------------------------------------------------------------
    localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
    localparam logic [31:0] CRC_INIT = 32'hffff_ffff;

endpackage

// [design/qmh_sticky_bank.sv]
// Purpose: Sticky event flags with write-one-to-clear
// Assumes: Set and clear are one-cycle pulses
// Notes:   A set in the clearing cycle wins so no event is lost

`timescale 1ns/1ps
`default_nettype none

module qmh_sticky_bank #(
    parameter int unsigned W = 16
) (
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic [W-1:0] set_pulse,
    input  wire logic [W-1:0] clr_pulse,
    output logic      [W-1:0] flag_r
);

    // ------------------------------------------------------------------
    // One flop per flag
    // ------------------------------------------------------------------
    for (genvar g = 0; g < W; g++) begin : g_flag
        // Set beats clear in the same cycle
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                flag_r[g] <= 1'b0;
            end else if (set_pulse[g]) begin
                flag_r[g] <= 1'b1;
            end else if (clr_pulse[g]) begin
                flag_r[g] <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// [design/qmh_top.sv]
// Purpose: Receive count threshold, transmit space request and multicast hash filter
// Assumes: AHB-Lite slave, one clock, queue levels synchronous to hclk
// Notes:   Zero wait states; read data is captured in the address phase
//
// Notes on behaviour
// - Eight-bit receive count threshold in low byte, reset zero, upper byte reserved.
// - With threshold enable set, frames held above threshold set receive status.
// - With monitor set, free transmit space covering request sets space status.
// - Hash table filters group addresses only in hash-perfect mode.
// - Index is six top CRC bits over the 48-bit destination address.
// - Top two index bits pick the word, low four the bit.
// - Indexed bit one accepts the multicast frame, zero drops it.
// - Receive-all plus multicast-with-MAC accepts every multicast frame.
// - Receive status is edge-set and cleared by writing one.
// - Status bit six reports transmit space available.

`timescale 1ns/1ps
`default_nettype none

module qmh_top #(
    parameter int unsigned THR_W = 8
) (
    input  wire logic                      hclk,
    input  wire logic                      hresetn,
    input  wire logic                      hsel,
    input  wire logic [qmh_pkg::ADDR_W-1:0] haddr,
    input  wire logic [1:0]                htrans,
    input  wire logic                      hwrite,
    input  wire logic [2:0]                hsize,
    input  wire logic [31:0]               hwdata,
    input  wire logic                      hready,
    output logic                           hreadyout,
    output logic                           hresp,
    output logic      [31:0]               hrdata,
    input  wire logic [THR_W-1:0]          rx_frames_held,
    input  wire logic [15:0]               tx_free_dwords,
    input  wire logic                      da_valid,
    input  wire logic [47:0]               da,
    output logic                           filt_done,
    output logic                           filt_accept,
    output logic                           irq
);
    import qmh_pkg::*;

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (THR_W < 1 || THR_W > 8) begin : g_bad_thr
        $error("THR_W must be 1 to 8");
    end

    // ------------------------------------------------------------------
    // Address decode helpers
    // ------------------------------------------------------------------
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        return (a[1:0] == 2'b00) && ((a >> (IDX_W + 2)) == '0);
    endfunction

    function automatic logic [IDX_W-1:0] addr_index(input logic [ADDR_W-1:0] a);
        return a[IDX_W+1:2];
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [THR_W-1:0] thresh_r;
    logic [15:0]      tx_request_r;
    logic [15:0]      hash_r [4];
    logic [15:0]      rxq_ctrl_r;
    logic [15:0]      txq_ctrl_r;
    logic [15:0]      rx_ctrl1_r;
    logic [15:0]      int_mask_r;
    logic [15:0]      status_r;
    logic [15:0]      status_set;
    logic [15:0]      status_clr;
    logic             wr_dph_r;
    logic [IDX_W-1:0] idx_dph_r;
    logic             rx_cond_d_r;
    logic             tx_cond_d_r;
    logic [5:0]       hash_index;
    logic             rx_cond;
    logic             tx_cond;
    logic             take;
    logic [15:0]      wdata16;

    assign take    = hsel && hready && htrans[1];
    assign wdata16 = hwdata[15:0];

    // Never stalls and never errors
    assign hreadyout = 1'b1;
    assign hresp     = HRESP_OK;

    // ------------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------------
    function automatic logic [15:0] read_value(input logic [IDX_W-1:0] i);
        logic [15:0] v;
        v = 16'h0000;
        case (i)
            IDX_INT_STATUS: v = status_r;
            IDX_RX_THRESH:  v = 16'(thresh_r);
            IDX_TX_REQUEST: v = tx_request_r;
            IDX_HASH_0:     v = hash_r[0];
            IDX_HASH_1:     v = hash_r[1];
            IDX_HASH_2:     v = hash_r[2];
            IDX_HASH_3:     v = hash_r[3];
            IDX_RXQ_CTRL:   v = rxq_ctrl_r;
            IDX_TXQ_CTRL:   v = txq_ctrl_r;
            IDX_RX_CTRL1:   v = rx_ctrl1_r;
            IDX_INT_MASK:   v = int_mask_r;
            default:        v = 16'h0000;
        endcase
        return v;
    endfunction

    // ------------------------------------------------------------------
    // AHB address phase capture
    // ------------------------------------------------------------------
    // Writes need a full word; narrower writes are dropped quietly
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_dph_r  <= 1'b0;
            idx_dph_r <= '0;
        end else if (hready) begin
            wr_dph_r  <= take && hwrite && addr_hit(haddr) && (hsize == HSIZE_WD);
            idx_dph_r <= addr_index(haddr);
        end
    end

    // Read data sampled at address phase; unmapped reads give zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            hrdata <= addr_hit(haddr) ? {16'h0000, read_value(addr_index(haddr))}
                                      : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------------
    // Register writes in the data phase
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            thresh_r     <= THR_W'(THRESH_RESET);
            tx_request_r <= REG16_RESET;
            rxq_ctrl_r   <= REG16_RESET;
            txq_ctrl_r   <= REG16_RESET;
            rx_ctrl1_r   <= REG16_RESET;
            int_mask_r   <= REG16_RESET;
        end else if (wr_dph_r) begin
            case (idx_dph_r)
                IDX_RX_THRESH:  thresh_r     <= wdata16[THR_W-1:0];
                IDX_TX_REQUEST: tx_request_r <= wdata16;
                IDX_RXQ_CTRL:   rxq_ctrl_r   <= wdata16 & RXQ_CTRL_MASK;
                IDX_TXQ_CTRL:   txq_ctrl_r   <= wdata16 & TXQ_CTRL_MASK;
                IDX_RX_CTRL1:   rx_ctrl1_r   <= wdata16 & RX_CTRL1_MASK;
                IDX_INT_MASK:   int_mask_r   <= wdata16 & INT_MASK_MASK;
                default:        ;
            endcase
        end
    end

    // Hash table words, one array slot per word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int k = 0; k < 4; k++) begin
                hash_r[k] <= REG16_RESET;
            end
        end else if (wr_dph_r) begin
            for (int k = 0; k < 4; k++) begin
                if (idx_dph_r == IDX_HASH_0 + IDX_W'(2 * k)) begin
                    hash_r[k] <= wdata16;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Queue level events
    // ------------------------------------------------------------------
    // Zero threshold fires on one frame; software must avoid it
    assign rx_cond = rxq_ctrl_r[RXQ_THR_EN_BIT] && (rx_frames_held > thresh_r);
    assign tx_cond = txq_ctrl_r[TXQ_MON_BIT] && (tx_free_dwords >= tx_request_r);

    // Edge detect so a standing level does not refire after clearing
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_cond_d_r <= 1'b0;
            tx_cond_d_r <= 1'b0;
        end else begin
            rx_cond_d_r <= rx_cond;
            tx_cond_d_r <= tx_cond;
        end
    end

    // Event and clear vectors for the status bank
    always_comb begin
        status_set = 16'h0000;
        status_set[ISR_RX_BIT]      = rx_cond && !rx_cond_d_r;
        status_set[ISR_TXSPACE_BIT] = tx_cond && !tx_cond_d_r;
        status_clr = (wr_dph_r && idx_dph_r == IDX_INT_STATUS) ? wdata16 : 16'h0000;
    end

    qmh_sticky_bank #(
        .W(16)
    ) u_status (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .set_pulse (status_set),
        .clr_pulse (status_clr),
        .flag_r    (status_r)
    );

    // Level interrupt while any unmasked flag stands
    assign irq = |(status_r & int_mask_r);

    // ------------------------------------------------------------------
    // Multicast hash filter
    // ------------------------------------------------------------------
    qmh_crc_index u_crc (
        .dest_addr  (da),
        .hash_index (hash_index)
    );

    // Verdict one cycle after the address is offered
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            filt_done   <= 1'b0;
            filt_accept <= 1'b0;
        end else begin
            filt_done <= da_valid;
            if (da_valid) begin
                if (!da[MCAST_DA_BIT] || !rx_ctrl1_r[RXC1_HASH_BIT]) begin
                    filt_accept <= 1'b1;
                end else if (rx_ctrl1_r[RXC1_RXALL_BIT] && rx_ctrl1_r[RXC1_MCMAC_BIT]) begin
                    filt_accept <= 1'b1;
                end else begin
                    filt_accept <= hash_r[hash_index[5:4]][hash_index[3:0]];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    logic mc_bypass;
    logic mc_hashed;
    assign mc_bypass = rx_ctrl1_r[RXC1_RXALL_BIT] && rx_ctrl1_r[RXC1_MCMAC_BIT];
    assign mc_hashed = da_valid && da[MCAST_DA_BIT] && rx_ctrl1_r[RXC1_HASH_BIT];

    sequence s_thr_read;
        take && !hwrite && addr_hit(haddr) && addr_index(haddr) == IDX_RX_THRESH;
    endsequence

    sequence s_rx_edge;
        rx_cond && !rx_cond_d_r;
    endsequence

    property p_thr_upper_zero;
        s_thr_read |=> hrdata[31:THR_W] == '0 && hrdata[THR_W-1:0] == $past(thresh_r);
    endproperty
    a_thr_upper_zero: assert property (p_thr_upper_zero)
        else $error("threshold readback wrong");

    property p_rx_sets;
        s_rx_edge |=> status_r[ISR_RX_BIT] ##1 1'b1;
    endproperty
    a_rx_sets: assert property (p_rx_sets)
        else $error("receive status not set");

    property p_rx_cause;
        $rose(status_r[ISR_RX_BIT]) |-> $past(rxq_ctrl_r[RXQ_THR_EN_BIT]) && $past(rx_cond);
    endproperty
    a_rx_cause: assert property (p_rx_cause)
        else $error("receive status without cause");

    property p_w1c;
        (status_clr[ISR_RX_BIT] && !status_set[ISR_RX_BIT]) |=> !status_r[ISR_RX_BIT];
    endproperty
    a_w1c: assert property (p_w1c)
        else $error("receive status not cleared");

    property p_tx_space;
        $rose(status_r[ISR_TXSPACE_BIT]) |-> $past(tx_free_dwords >= tx_request_r)
                                             && $past(txq_ctrl_r[TXQ_MON_BIT]);
    endproperty
    a_tx_space: assert property (p_tx_space)
        else $error("space status without room");

    property p_tx_sets;
        (tx_cond && !tx_cond_d_r) |=> status_r[ISR_TXSPACE_BIT];
    endproperty
    a_tx_sets: assert property (p_tx_sets)
        else $error("space status not set");

    property p_no_hash_pass;
        (da_valid && !rx_ctrl1_r[RXC1_HASH_BIT]) |=> filt_done && filt_accept;
    endproperty
    a_no_hash_pass: assert property (p_no_hash_pass)
        else $error("frame filtered outside hash mode");

    property p_bypass;
        (mc_hashed && mc_bypass) |=> filt_accept;
    endproperty
    a_bypass: assert property (p_bypass)
        else $error("receive-all multicast dropped");

    // Table bit captured at the offer edge, so a same-cycle table write cannot confuse it
    property p_hash_bit;
        logic tbit;
        (mc_hashed && !mc_bypass, tbit = hash_r[hash_index[5:4]][hash_index[3:0]])
            |=> filt_accept == tbit;
    endproperty
    a_hash_bit: assert property (p_hash_bit)
        else $error("hash verdict wrong");

endmodule

`default_nettype wire

// [verif/qmh_host.sv]
// Purpose: AHB-Lite host model issuing single word transfers
// Assumes: One slave, hready looped back from hreadyout
// Notes:   Write data shows inverted junk outside data phases
`timescale 1ns/1ps
`default_nettype none
module qmh_host (
    input  wire logic        hclk,
    input  wire logic        hready,
    input  wire logic [31:0] hrdata,
    output logic             hsel,
    output logic [11:0]      haddr,
    output logic [1:0]       htrans,
    output logic             hwrite,
    output logic [2:0]       hsize,
    output logic [31:0]      hwdata
);
    import qmh_pkg::*;
    // Idle bus at time zero
    initial begin
        hsel = 1'b0;
        haddr = 12'h000;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = HSIZE_WD;
        hwdata = 32'h5a5a_5a5a;
    end
    // ------------------------------------------------------------
    // One transfer; waits on hready, never on a fixed count
    // ------------------------------------------------------------
    task automatic xfer(input logic w, input logic [8:0] idx, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {1'b0, idx, 2'b00};
        htrans <= HTRANS_NS;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        q = hrdata;
        hsel <= 1'b0;
        hwdata <= ~d; // Released lines must not look valid
    endtask
endmodule
`default_nettype wire

// [verif/qmh_top_tb.sv]
// Purpose: Self-checking bench for threshold, space request and hash filter
// Assumes: Zero-wait slave; status sets one edge after its condition rises
// Notes:   Hash expectations come from a bench CRC model
`timescale 1ns/1ps
`default_nettype none
module qmh_top_tb;
    import qmh_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic        da_valid, filt_done, filt_accept, irq;
    logic [11:0] haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd, seed;
    logic [7:0]  rx_frames_held;
    logic [15:0] tx_free_dwords, n;
    logic [47:0] da, a;
    logic [31:0] r32;
    logic        e_acc;
    logic [63:0] tbl;
    logic [15:0] sh [int];
    logic [8:0]  regs [6];
    int          errors, checks_done;
    qmh_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .rx_frames_held(rx_frames_held), .tx_free_dwords(tx_free_dwords),
        .da_valid(da_valid), .da(da), .filt_done(filt_done),
        .filt_accept(filt_accept), .irq(irq));
    qmh_host host (.hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
    // ------------------------------------------------------------
    // Clock, random source, compare and closing
    // ------------------------------------------------------------
    initial begin
        hclk = 1'b0;
        forever #12.5 hclk = ~hclk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // Hang guard, well past the expected run
    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        conclude();
    end
    // ------------------------------------------------------------
    // Bus helpers with a shadow register model
    // ------------------------------------------------------------
    task automatic wr(input logic [8:0] idx, input logic [31:0] d);
        host.xfer(1'b1, idx, d, rd);
        sh[idx] = d[15:0];
    endtask
    task automatic rdchk(input logic [8:0] idx, input logic [31:0] m);
        host.xfer(1'b0, idx, 32'h0000_0000, rd);
        check($sformatf("reg %h", idx), rd & m, {16'h0000, sh[idx]} & m);
        check("hresp", {31'b0, hresp}, {31'b0, HRESP_OK});
    endtask
    task automatic stat(input logic [15:0] s, input logic i);
        host.xfer(1'b0, IDX_INT_STATUS, 32'h0000_0000, rd);
        check("status", rd, {16'h0000, s});
        check("irq", {31'b0, irq}, {31'b0, i});
    endtask
    // Reference CRC: first byte first, each byte low bit first
    function automatic logic [5:0] hidx(input logic [47:0] x);
        logic [31:0] c;
        logic        fb;
        c = CRC_INIT;
        for (int b = 5; b >= 0; b--) begin
            for (int k = 0; k < 8; k++) begin
                fb = c[31] ^ x[8*b+k];
                c = {c[30:0], 1'b0};
                if (fb) c = c ^ CRC_POLY;
            end
        end
        return c[31:26];
    endfunction
    task automatic frame(input logic [47:0] x, input logic e);
        @(posedge hclk);
        da_valid <= 1'b1;
        da <= x;
        @(posedge hclk);
        da_valid <= 1'b0;
        da <= ~x;
        #1;
        check("filt_done", {31'b0, filt_done}, 32'h0000_0001);
        check("filt_accept", {31'b0, filt_accept}, {31'b0, e});
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        seed = 32'd99682;
        errors = 0;
        checks_done = 0;
        hresetn = 1'b0;
        rx_frames_held = 8'h00;
        tx_free_dwords = 16'h0000;
        da_valid = 1'b0;
        da = 48'h0;
        regs = '{IDX_RX_THRESH, IDX_TX_REQUEST, IDX_HASH_0, IDX_HASH_1, IDX_HASH_2, IDX_HASH_3};
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            sh[regs[i]] = 16'h0000;
            rdchk(regs[i], 32'hffff_ffff);
        end
        for (int i = 1; i < 6; i++) wr(regs[i], rnd());
        for (int i = 1; i < 6; i++) rdchk(regs[i], 32'hffff_ffff);
        wr(9'h1ff, 32'h0000_ffff);
        sh[9'h1ff] = 16'h0000;
        rdchk(9'h1ff, 32'hffff_ffff);
        $display("registers test done");
        // Threshold three, never one while receiving
        wr(IDX_RX_THRESH, 32'h0000_0003);
        rdchk(IDX_RX_THRESH, 32'h0000_00ff);
        wr(IDX_RXQ_CTRL, 32'h0000_0001 << RXQ_THR_EN_BIT);
        @(posedge hclk);
        rx_frames_held <= 8'd3;
        stat(16'h0000, 1'b0);
        @(posedge hclk);
        rx_frames_held <= 8'd4;
        stat(16'h2000, 1'b0);
        wr(IDX_INT_MASK, 32'h0000_2000);
        stat(16'h2000, 1'b1);
        wr(IDX_INT_STATUS, 32'h0000_2000);
        stat(16'h0000, 1'b0);
        $display("receive threshold test done");
        // Space request just above, then equal to, free space
        r32 = rnd();
        n = 16'h0100 + {8'h00, r32[7:0]};
        tx_free_dwords <= n - 16'h0001;
        wr(IDX_TX_REQUEST, {16'h0000, n});
        wr(IDX_TXQ_CTRL, 32'h0000_0001 << TXQ_MON_BIT);
        stat(16'h0000, 1'b0);
        tx_free_dwords <= n;
        stat(16'h0040, 1'b0);
        wr(IDX_INT_MASK, 32'h0000_0040);
        stat(16'h0040, 1'b1);
        wr(IDX_INT_STATUS, 32'h0000_0040);
        stat(16'h0000, 1'b0);
        $display("transmit space test done");
        // Hash modes: on, off, receive-all with MAC, receive-all alone
        for (int i = 0; i < 4; i++) wr(regs[i+2], rnd());
        tbl = {sh[IDX_HASH_3], sh[IDX_HASH_2], sh[IDX_HASH_1], sh[IDX_HASH_0]};
        for (int m = 0; m < 4; m++) begin
            wr(IDX_RX_CTRL1, (m == 1 ? 32'h0 : 32'h0800) | (m >= 2 ? 32'h0010 : 32'h0)
                | (m == 2 ? 32'h0100 : 32'h0));
            for (int j = 0; j < 10; j++) begin
                r32 = rnd();
                a = {r32, 16'h0000};
                r32 = rnd();
                a[15:0] = r32[15:0];
                a[MCAST_DA_BIT] = (j != 9);
                e_acc = !a[MCAST_DA_BIT] || m == 1 || m == 2 || tbl[hidx(a)];
                frame(a, e_acc);
            end
        end
        $display("hash filter test done");
        conclude();
    end
endmodule
`default_nettype wire
